/* hdl/scd_pkg.sv */
package scd_pkg;

  localparam int unsigned CLOCK_PERIOD_NS = 4;
  localparam int unsigned APB_ADDR_W = 12;

  // Printed offsets are indices; byte address is four times the index
  localparam logic [7:0] CTRL0_INDEX = 8'hE0;
  localparam logic [7:0] CTRL1_INDEX = 8'hE1;
  localparam logic [11:0] CTRL0_ADDR = {2'h0, CTRL0_INDEX, 2'h0};
  localparam logic [11:0] CTRL1_ADDR = {2'h0, CTRL1_INDEX, 2'h0};
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  // Control register zero fields
  localparam int unsigned CPU_RATE_LSB = 0;
  localparam int unsigned SLEEP_LSB = 3;
  localparam int unsigned RESERVED_BIT = 5;
  localparam int unsigned PLL_BIT = 6;
  localparam int unsigned SOURCE_SEL_BIT = 7;
  // Control register one fields
  localparam int unsigned DIV2_LSB = 0;
  localparam int unsigned DIV1_LSB = 4;

  // Log2 of CPU divide ratio relative to the half-rate clock, per code
  localparam logic [7:0][3:0] CPU_LOG2 = {4'h8, 4'h7, 4'h5, 4'h4, 4'h0, 4'h1, 4'h2, 4'h3};
  // Log2 of sleep divide ratio relative to the low-speed clock, per code
  localparam logic [3:0][3:0] SLEEP_LOG2 = {4'hF, 4'hC, 4'h9, 4'h6};

  localparam int unsigned CRYSTAL_HZ = 32768;
  localparam int unsigned PLL_NOMINAL_HZ = 23986176;
  localparam logic [9:0] PLL_LOCK_RATIO = 10'(PLL_NOMINAL_HZ / CRYSTAL_HZ);

  typedef struct packed {
    logic fast;
    logic half_rate;
    logic first_var;
    logic second_var;
    logic cpu;
    logic sleep;
  } scd_ticks_t;

endpackage

/* hdl/scd_clock_divider.sv */
// Our own choice: register access over APB.
`timescale 1ns/10ps
// The block clock stands in for the main oscillator. Every divided clock
// leaves as a one-cycle enable strobe, so no divided net ever drives a clock pin.
module scd_clock_divider
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Low-speed oscillator pins
  input wire logic internal_low_speed_osc,
  input wire logic crystal_osc,
  // Derived clock strobes and oscillator control
  output scd_ticks_t ticks,
  output logic low_speed_clock,
  output logic pll_enable,
  output logic [9:0] pll_lock_ratio
);

  logic [7:0] oscillator_control_zero;
  logic [7:0] oscillator_control_one;
  logic wr_access;
  logic rd_setup;
  logic hit0;
  logic hit1;

  logic half_phase;
  logic half_tick;
  logic [3:0] div1_cnt;
  logic [3:0] div2_cnt;
  logic tick1_now;
  logic tick2_now;
  logic [2:0] cpu_code;
  logic [7:0] cpu_cnt;
  logic [7:0] cpu_mask;
  logic cpu_tick_now;

  logic [2:0] ilo_sync;
  logic [2:0] xtal_sync;
  logic ilo_level;
  logic xtal_level;
  logic low_prev;
  logic low_rise;
  logic [1:0] sleep_code;
  logic [14:0] sleep_cnt;
  logic [14:0] sleep_mask;
  logic sleep_tick_now;

  // Register access
  assign hit0 = (paddr == CTRL0_ADDR);
  assign hit1 = (paddr == CTRL1_ADDR);
  assign wr_access = clock_en && psel && penable && pwrite;
  assign rd_setup = clock_en && psel && !penable && !pwrite;
  // Zero wait states; a frozen block holds the bus until it runs again
  assign pready = clock_en;
  assign pslverr = psel && penable && !(hit0 || hit1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oscillator_control_zero <= CTRL0_RESET;
    end else if (wr_access && hit0) begin
      // Takes effect at the completing edge, no deferral
      oscillator_control_zero <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oscillator_control_one <= CTRL1_RESET;
    end else if (wr_access && hit1) begin
      oscillator_control_one <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle so it leaves from flip-flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (hit0) begin
        prdata <= {24'h00_0000, oscillator_control_zero};
      end else if (hit1) begin
        prdata <= {24'h00_0000, oscillator_control_one};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // PLL control; bit 5 is plain storage with no effect
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pll_enable <= 1'b0;
      pll_lock_ratio <= 10'h000;
    end else if (clock_en) begin
      pll_enable <= oscillator_control_zero[PLL_BIT];
      // Oscillator is steered to this multiple of the crystal while enabled
      pll_lock_ratio <= oscillator_control_zero[PLL_BIT] ? PLL_LOCK_RATIO : 10'h000;
    end
  end

  // Half-rate phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_phase <= 1'b0;
    end else if (clock_en) begin
      half_phase <= !half_phase;
    end
  end

  assign half_tick = clock_en && half_phase;

  // First variable divider. Wrap on >= so a smaller N never runs past it.
  assign tick1_now = half_tick && (div1_cnt >= oscillator_control_one[DIV1_LSB +: 4]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div1_cnt <= 4'h0;
    end else if (tick1_now) begin
      div1_cnt <= 4'h0;
    end else if (half_tick) begin
      div1_cnt <= div1_cnt + 4'h1;
    end
  end

  // Second variable divider runs on first variable strobes
  assign tick2_now = tick1_now && (div2_cnt >= oscillator_control_one[DIV2_LSB +: 4]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div2_cnt <= 4'h0;
    end else if (tick2_now) begin
      div2_cnt <= 4'h0;
    end else if (tick1_now) begin
      div2_cnt <= div2_cnt + 4'h1;
    end
  end

  // CPU divider: a free-running count masked by the selected ratio. A new
  // code only changes which strobes pass, so no short or runt period appears.
  assign cpu_code = oscillator_control_zero[CPU_RATE_LSB +: 3];
  assign cpu_mask = 8'((9'h001 << CPU_LOG2[cpu_code]) - 9'h001);
  assign cpu_tick_now = half_tick && ((cpu_cnt & cpu_mask) == cpu_mask);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_cnt <= 8'h00;
    end else if (half_tick) begin
      cpu_cnt <= cpu_cnt + 8'h01;
    end
  end

  // Low-speed pins: three stages, a level counts once stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ilo_sync <= 3'h0;
      xtal_sync <= 3'h0;
    end else if (clock_en) begin
      ilo_sync <= {ilo_sync[1:0], internal_low_speed_osc};
      xtal_sync <= {xtal_sync[1:0], crystal_osc};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ilo_level <= 1'b0;
      xtal_level <= 1'b0;
    end else if (clock_en) begin
      if (ilo_sync[1] == ilo_sync[2]) begin
        ilo_level <= ilo_sync[2];
      end
      if (xtal_sync[1] == xtal_sync[2]) begin
        xtal_level <= xtal_sync[2];
      end
    end
  end

  // Source mux; a switch may cut a period short, which software tolerates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_speed_clock <= 1'b0;
      low_prev <= 1'b0;
    end else if (clock_en) begin
      low_speed_clock <= oscillator_control_zero[SOURCE_SEL_BIT] ? xtal_level : ilo_level;
      low_prev <= low_speed_clock;
    end
  end

  assign low_rise = clock_en && low_speed_clock && !low_prev;

  // Sleep divider counts low-speed rising edges
  assign sleep_code = oscillator_control_zero[SLEEP_LSB +: 2];
  assign sleep_mask = 15'((16'h0001 << SLEEP_LOG2[sleep_code]) - 16'h0001);
  assign sleep_tick_now = low_rise && ((sleep_cnt & sleep_mask) == sleep_mask);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_cnt <= 15'h0000;
    end else if (low_rise) begin
      sleep_cnt <= sleep_cnt + 15'h0001;
    end
  end

  // Registered strobes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ticks <= '0;
    end else if (clock_en) begin
      ticks.fast <= 1'b1;
      ticks.half_rate <= half_tick;
      ticks.first_var <= tick1_now;
      ticks.second_var <= tick2_now;
      ticks.cpu <= cpu_tick_now;
      ticks.sleep <= sleep_tick_now;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_fast;
    clock_en |=> ticks.fast;
  endproperty
  a_fast: assert property (p_fast) else $error("fast strobe not continuous");

  property p_half;
    ticks.half_rate && clock_en |=> !ticks.half_rate;
  endproperty
  a_half: assert property (p_half) else $error("half-rate strobe repeated");

  property p_div1;
    half_tick && (div1_cnt == oscillator_control_one[DIV1_LSB +: 4]) |->
      tick1_now ##1 div1_cnt == 4'h0;
  endproperty
  a_div1: assert property (p_div1) else $error("first divider did not wrap at N");

  property p_div2;
    tick1_now && (div2_cnt == oscillator_control_one[DIV2_LSB +: 4]) |-> tick2_now;
  endproperty
  a_div2: assert property (p_div2) else $error("second divider did not wrap at N");

  property p_cpu_full;
    (cpu_code == 3'h3) |-> (cpu_tick_now == half_tick);
  endproperty
  a_cpu_full: assert property (p_cpu_full) else $error("code 3 not 24 MHz");

  property p_cpu_slow;
    (cpu_code == 3'h7) && cpu_tick_now |-> (cpu_cnt == 8'hFF);
  endproperty
  a_cpu_slow: assert property (p_cpu_slow) else $error("code 7 not divide by 256");

  property p_cpu_now;
    wr_access && hit0 |=> cpu_code == $past(pwdata[2:0]);
  endproperty
  a_cpu_now: assert property (p_cpu_now) else $error("CPU rate write deferred");

  property p_sleep;
    sleep_tick_now && (sleep_code == 2'h1) |-> (sleep_cnt[8:0] == 9'h1FF);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep code 1 not divide by 512");

  property p_pll;
    clock_en && oscillator_control_zero[PLL_BIT] |=>
      pll_enable && (pll_lock_ratio == PLL_LOCK_RATIO);
  endproperty
  a_pll: assert property (p_pll) else $error("PLL enable not applied");

  property p_pll_off;
    clock_en && !oscillator_control_zero[PLL_BIT] |=> !pll_enable && (pll_lock_ratio == 10'h000);
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("PLL disable not applied");

  property p_half_alt;
    clock_en |=> half_phase != $past(half_phase);
  endproperty
  a_half_alt: assert property (p_half_alt) else $error("half-rate phase stalled");

  property p_div1_hold;
    half_tick && (div1_cnt < oscillator_control_one[DIV1_LSB +: 4]) |-> !tick1_now;
  endproperty
  a_div1_hold: assert property (p_div1_hold) else $error("first divider wrapped early");

  property p_div2_hold;
    tick2_now |-> tick1_now;
  endproperty
  a_div2_hold: assert property (p_div2_hold) else $error("second strobe without first");

  property p_cpu_half;
    cpu_tick_now |-> half_tick;
  endproperty
  a_cpu_half: assert property (p_cpu_half) else $error("CPU strobe faster than 24 MHz");

  property p_cpu_code0;
    cpu_tick_now && (cpu_code == 3'h0) |-> (cpu_cnt[2:0] == 3'h7);
  endproperty
  a_cpu_code0: assert property (p_cpu_code0) else $error("code 0 not divide by 8");

  property p_cpu_code4;
    cpu_tick_now && (cpu_code == 3'h4) |-> (cpu_cnt[3:0] == 4'hF);
  endproperty
  a_cpu_code4: assert property (p_cpu_code4) else $error("code 4 not divide by 16");

  property p_cpu_code6;
    cpu_tick_now && (cpu_code == 3'h6) |-> (cpu_cnt[6:0] == 7'h7F);
  endproperty
  a_cpu_code6: assert property (p_cpu_code6) else $error("code 6 not divide by 128");

  property p_low_mux;
    clock_en |=> low_speed_clock == ($past(oscillator_control_zero[SOURCE_SEL_BIT]) ?
      $past(xtal_level) : $past(ilo_level));
  endproperty
  a_low_mux: assert property (p_low_mux) else $error("low-speed source mux wrong");

  property p_sleep_src;
    sleep_tick_now |-> low_rise;
  endproperty
  a_sleep_src: assert property (p_sleep_src) else $error("sleep strobe off a rise");

  property p_sleep_fast;
    sleep_tick_now && (sleep_code == 2'h0) |-> (sleep_cnt[5:0] == 6'h3F);
  endproperty
  a_sleep_fast: assert property (p_sleep_fast) else $error("sleep code 0 not by 64");

  property p_sleep_mid;
    sleep_tick_now && (sleep_code == 2'h2) |-> (sleep_cnt[11:0] == 12'hFFF);
  endproperty
  a_sleep_mid: assert property (p_sleep_mid) else $error("sleep code 2 not by 4096");

  property p_sleep_slow;
    sleep_tick_now && (sleep_code == 2'h3) |-> (sleep_cnt == 15'h7FFF);
  endproperty
  a_sleep_slow: assert property (p_sleep_slow) else $error("sleep code 3 not by 32768");

  c_cpu_change: cover property (wr_access && hit0 ##1 cpu_tick_now);
  c_crystal: cover property (low_rise && oscillator_control_zero[SOURCE_SEL_BIT]);
  c_sleep: cover property (sleep_tick_now && sleep_code == 2'h3);
  c_second: cover property (tick2_now && oscillator_control_one == 8'hFF);
  c_err: cover property (pslverr && pready);

endmodule

/* verif/system_clock_divider_select_tb.sv */
`timescale 1ns/10ps
module system_clock_divider_select_tb;
  import scd_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clock_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic internal_low_speed_osc = 1'b0;
  logic crystal_osc = 1'b0;
  scd_ticks_t ticks;
  logic low_speed_clock;
  logic pll_enable;
  logic [9:0] pll_lock_ratio;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int cpu_div[8] = '{8, 4, 2, 1, 16, 32, 128, 256};
  logic [7:0] div_sets[3] = '{8'h00, 8'h30, 8'hFF};
  logic [31:0] rd;
  logic err;
  int n;

  scd_clock_divider DUT (
    .clock(clock), .rst(rst), .clock_en(clock_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_low_speed_osc(internal_low_speed_osc), .crystal_osc(crystal_osc),
    .ticks(ticks), .low_speed_clock(low_speed_clock), .pll_enable(pll_enable),
    .pll_lock_ratio(pll_lock_ratio)
  );

  always #2 clock = ~clock;

  // Two distinct low-speed sources so the source mux shows in the sleep period
  always @(posedge clock) begin
    cycles <= cycles + 1;
    // Each level lasts at least two cycles so the synchroniser stages can agree
    if (cycles[0]) begin
      crystal_osc <= ~crystal_osc;
    end
    if (cycles[1:0] == 2'b11) begin
      internal_low_speed_osc <= ~internal_low_speed_osc;
    end
  end

  // Longest scenario is the crystal 4096 divide, about 33k cycles
  always @(posedge clock) begin
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask

  function automatic logic tick(input int sel);
    case (sel)
      0: return ticks.fast;
      1: return ticks.half_rate;
      2: return ticks.first_var;
      3: return ticks.second_var;
      4: return ticks.cpu;
      default: return ticks.sleep;
    endcase
  endfunction

  // Lets old-setting strobes and a source-switch glitch pass, then skips the
  // first strobe, which may follow a mid-period setting change
  task automatic measure(input int sel, input int exp, input string what);
    int c;
    c = 0;
    repeat (8) @(posedge clock);
    while (tick(sel) !== 1'b1 && c < 20000) begin
      @(posedge clock);
      c++;
    end
    @(posedge clock);
    n = 1;
    while (tick(sel) !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk(what, 32'(exp), 32'(n));
  endtask

  initial begin
    int c;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd_chk(CTRL0_ADDR, 8'h00, "ctrl0 reset");
    rd_chk(CTRL1_ADDR, 8'h00, "ctrl1 reset");
    apb(1'b1, CTRL0_ADDR, 8'h85);
    apb(1'b1, CTRL0_ADDR, 8'hE5);
    rd_chk(CTRL0_ADDR, 8'hE5, "ctrl0 readback");
    chk("pll enable", 32'h1, {31'h0, pll_enable});
    chk("pll ratio", 32'h2DC, {22'h0, pll_lock_ratio});
    apb(1'b1, CTRL0_ADDR, 8'h25);
    repeat (2) @(posedge clock);
    chk("pll off", 32'h0, {21'h0, pll_enable, pll_lock_ratio});
    apb(1'b1, 12'h388, 8'hFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    rd_chk(12'h388, 8'h00, "unmapped read");
    rd_chk(CTRL0_ADDR, 8'h25, "ctrl0 kept");
    measure(0, 1, "fast period");
    measure(1, 2, "half period");
    foreach (div_sets[i]) begin
      apb(1'b1, CTRL1_ADDR, div_sets[i]);
      measure(2, 2 * (div_sets[i][7:4] + 1), "first var period");
      measure(3, 2 * (div_sets[i][7:4] + 1) * (div_sets[i][3:0] + 1), "second var");
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CTRL0_ADDR, 8'(k));
      measure(4, 2 * cpu_div[k], "cpu period");
    end
    apb(1'b1, CTRL0_ADDR, 8'h03);
    c = 0;
    while (ticks.cpu !== 1'b1 && c < 20) begin
      @(posedge clock);
      c++;
    end
    chk("cpu switch delay", 32'h1, {31'h0, c <= 4});
    @(posedge clock);
    clock_en <= 1'b0;
    @(negedge clock);
    chk("pready frozen", 32'h0, {31'h0, pready});
    @(posedge clock);
    clock_en <= 1'b1;
    measure(5, 512, "sleep internal 00");
    apb(1'b1, CTRL0_ADDR, 8'h83);
    measure(5, 256, "sleep crystal 00");
    apb(1'b1, CTRL0_ADDR, 8'h8B);
    measure(5, 2048, "sleep crystal 01");
    apb(1'b1, CTRL0_ADDR, 8'h93);
    measure(5, 16384, "sleep crystal 10");
    summarize();
  end
endmodule
